// [hw/lea_pkg.sv]
// Constants shared by the line energy accumulator
package lea_pkg;
	// Register port widths
	localparam int LEA_ADDR_W = 6;
	localparam int LEA_WDATA_W = 16;
	localparam int LEA_RDATA_W = 24;

	// Register offsets
	localparam logic [5:0] LEA_ADDR_LINE_ACTIVE = 6'h04;
	localparam logic [5:0] LEA_ADDR_LINE_APPARENT = 6'h05;
	localparam logic [5:0] LEA_ADDR_MEASUREMENT_MODE_REG = 6'h0b;
	localparam logic [5:0] LEA_ADDR_WAVEFORM = 6'h0c;
	localparam logic [5:0] LEA_ADDR_POWER_MODE = 6'h0d;
	localparam logic [5:0] LEA_ADDR_IRQ_ENABLE = 6'h0f;
	localparam logic [5:0] LEA_ADDR_IRQ_STATUS = 6'h10;
	localparam logic [5:0] LEA_ADDR_HALF_CYCLE = 6'h13;
	localparam logic [5:0] LEA_ADDR_GAIN = 6'h18;

	// Field positions
	localparam int LEA_MEASUREMENT_MODE_REG_ZX_LSB = 4;
	localparam int LEA_WAV_REACTIVE_BIT = 5;
	localparam int LEA_GAIN_ABS_BIT = 2;
	localparam int LEA_PM_TERM_LSB = 3;
	localparam int LEA_PM_COMB_LSB = 6;
	localparam int LEA_IRQ_LINE_BIT = 0;

	// Reset values
	localparam logic [7:0] LEA_MEASUREMENT_MODE_REG_RST = 8'h00;
	localparam logic [7:0] LEA_WAVEFORM_RST = 8'h00;
	localparam logic [7:0] LEA_POWER_MODE_RST = 8'h38;
	localparam logic [7:0] LEA_GAIN_RST = 8'h00;
	localparam logic [7:0] LEA_IRQ_ENABLE_RST = 8'h00;
	localparam logic [15:0] LEA_HALF_CYCLE_RST = 16'hffff;

	// Power combination codes
	localparam logic [1:0] LEA_COMB_WYE = 2'h0;
	localparam logic [1:0] LEA_COMB_DELTA = 2'h1;
	localparam logic [1:0] LEA_COMB_MIXED = 2'h2;

	// Timing and scaling
	localparam int LEA_SAMPLE_DIV = 4;
	localparam int LEA_LINE_SCALE_SH = 2;
	localparam int LEA_LPF_SH = 8;

	typedef enum logic [1:0] {
		LEA_ST_HOLD = 2'b01,
		LEA_ST_RUN  = 2'b10
	} lea_state_t;
endpackage

// [hw/lea_line_energy.sv]
// Line energy accumulator over a programmed number of half line cycles
// Overview of operation
// RULE_01 - Active power is summed into line active energy over counted half cycles.
// RULE_02 - Line accumulation always runs; there is no enable for it.
// RULE_03 - Host should select one phase only; several phases may under-accumulate.
// RULE_04 - Mode bits 4, 5, 6 add phase A, B, C crossings to count.
// RULE_05 - A selected phase also enables its crossing detect, timeout, period logic.
// RULE_06 - Half-cycle target is an unsigned 16-bit register, up to 65535.
// RULE_07 - Period completion sets the end-of-period flag in interrupt status.
// RULE_08 - With its enable set, completion also pulls the interrupt line low.
// RULE_09 - Three term-select bits enable the first, second and third sum terms.
// RULE_10 - Combination field picks wye, two-wattmeter or mixed sum formula.
// RULE_11 - Current samples used are gain corrected and high-pass filtered.
// RULE_12 - Line energy uses the active path with four times finer LSB.
// RULE_13 - Waveform bit 5 routes reactive to line active, active to line apparent.
// RULE_14 - In reactive mode active energy adds ignoring each phase sign.
// RULE_15 - In reactive mode term-select bits pick phases for both registers.
// RULE_16 - In normal mode gain bit 2 picks signed or absolute summation.
// RULE_17 - Gain bit 2 high means absolute sum, low means signed sum.
// RULE_18 - Reactive uses voltage times shifted current, then a low-pass filter.
// RULE_19 - Total reactive power is the sum over enabled phases.
// RULE_20 - Software uses reactive result for sign only, magnitude by power triangle.
// RULE_21 - At period end results latch and the counter reloads for a new period.
`timescale 1ns/10ps
module lea_line_energy #(
	parameter int SAMPLE_W = 16,
	parameter int ACC_W    = 48,
	parameter int DIV      = lea_pkg::LEA_SAMPLE_DIV
) (
	// Clock and reset
	input  wire logic                               mclk,
	input  wire logic                               resetn,
	// Register port
	input  wire logic [lea_pkg::LEA_ADDR_W-1:0]     reg_addr,
	input  wire logic                               reg_we,
	input  wire logic [lea_pkg::LEA_WDATA_W-1:0]    reg_wdata,
	input  wire logic                               reg_re,
	output logic      [lea_pkg::LEA_RDATA_W-1:0]    reg_rdata,
	// Voltage samples per phase
	input  wire logic signed [SAMPLE_W-1:0]         volt_a,
	input  wire logic signed [SAMPLE_W-1:0]         volt_b,
	input  wire logic signed [SAMPLE_W-1:0]         volt_c,
	// Corrected current samples per phase
	input  wire logic signed [SAMPLE_W-1:0]         curr_a,
	input  wire logic signed [SAMPLE_W-1:0]         curr_b,
	input  wire logic signed [SAMPLE_W-1:0]         curr_c,
	// Phase shifted current samples per phase
	input  wire logic signed [SAMPLE_W-1:0]         quad_a,
	input  wire logic signed [SAMPLE_W-1:0]         quad_b,
	input  wire logic signed [SAMPLE_W-1:0]         quad_c,
	// Total apparent power sample
	input  wire logic        [2*SAMPLE_W-1:0]       apparent_power,
	// Zero crossing pulses, bit 0 is phase A
	input  wire logic        [2:0]                  zero_cross,
	// Zero crossing support enables, bit 0 is phase A
	output logic             [2:0]                  zx_enable,
	// Period completion pulse
	output logic                                    period_done,
	// Open-drain interrupt line
	output logic                                    irq_n_o,
	output logic                                    irq_n_oe
);
	import lea_pkg::*;

	localparam int TW = 2 * SAMPLE_W + 1;
	localparam int SW = TW + 3;
	localparam int OUT_LSB = ACC_W - LEA_RDATA_W;

	// Refuse parameter values the datapath cannot hold
	if (SAMPLE_W < 4 || ACC_W < SW + LEA_LINE_SCALE_SH + 2 || DIV < 1) begin : g_param_check
		$error("lea_line_energy: unsupported parameter values");
	end

	// Configuration registers
	logic [7:0]  measurement_mode_reg_reg;
	logic [7:0]  waveform_reg;
	logic [7:0]  power_mode_reg;
	logic [7:0]  gain_reg;
	logic [7:0]  irq_enable_reg;
	logic [15:0] half_cycle_count_reg;

	logic [2:0] phase_sel;
	logic [2:0] line_term_select;
	logic [1:0] comb_sel;
	logic       reactive_mode;
	logic       abs_mode;

	assign phase_sel        = measurement_mode_reg_reg[LEA_MEASUREMENT_MODE_REG_ZX_LSB +: 3];
	assign line_term_select = power_mode_reg[LEA_PM_TERM_LSB +: 3];
	assign comb_sel         = power_mode_reg[LEA_PM_COMB_LSB +: 2];
	assign reactive_mode    = waveform_reg[LEA_WAV_REACTIVE_BIT];
	assign abs_mode         = gain_reg[LEA_GAIN_ABS_BIT];

	logic wr_half;
	assign wr_half = reg_we && reg_addr == LEA_ADDR_HALF_CYCLE;

	// Register writes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			measurement_mode_reg_reg            <= LEA_MEASUREMENT_MODE_REG_RST;
			waveform_reg         <= LEA_WAVEFORM_RST;
			power_mode_reg       <= LEA_POWER_MODE_RST;
			gain_reg             <= LEA_GAIN_RST;
			irq_enable_reg       <= LEA_IRQ_ENABLE_RST;
			half_cycle_count_reg <= LEA_HALF_CYCLE_RST;
		end else if (reg_we) begin
			case (reg_addr)
				LEA_ADDR_MEASUREMENT_MODE_REG:      measurement_mode_reg_reg <= reg_wdata[7:0];
				LEA_ADDR_WAVEFORM:   waveform_reg <= reg_wdata[7:0];
				LEA_ADDR_POWER_MODE: power_mode_reg <= reg_wdata[7:0];
				LEA_ADDR_GAIN:       gain_reg <= reg_wdata[7:0];
				LEA_ADDR_IRQ_ENABLE: irq_enable_reg <= reg_wdata[7:0];
				LEA_ADDR_HALF_CYCLE: half_cycle_count_reg <= reg_wdata; // RULE_06
				default: ;
			endcase
		end
	end

	// Sample rate enable
	logic [$clog2(DIV+1)-1:0] div_reg;
	logic                     sample_en;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div_reg   <= '0;
			sample_en <= 1'b0;
		end else if (div_reg == ($clog2(DIV+1))'(DIV - 1)) begin
			div_reg   <= '0;
			sample_en <= 1'b1;
		end else begin
			div_reg   <= div_reg + 1'b1;
			sample_en <= 1'b0;
		end
	end

	// Per-term currents after the combination formula
	logic signed [SAMPLE_W-1:0] volt [3];
	logic signed [SAMPLE_W:0]   act_cur [3];
	logic signed [SAMPLE_W:0]   rea_cur [3];
	logic signed [TW-1:0]       act_prod [3];
	logic signed [TW-1:0]       rea_prod [3];

	always_comb begin
		volt[0] = volt_a;
		volt[1] = volt_b;
		volt[2] = volt_c;
		act_cur[0] = (SAMPLE_W+1)'(curr_a); // RULE_11
		act_cur[1] = (SAMPLE_W+1)'(curr_b);
		act_cur[2] = (SAMPLE_W+1)'(curr_c);
		rea_cur[0] = (SAMPLE_W+1)'(quad_a); // RULE_18
		rea_cur[1] = (SAMPLE_W+1)'(quad_b);
		rea_cur[2] = (SAMPLE_W+1)'(quad_c);
		if (comb_sel == LEA_COMB_DELTA || comb_sel == LEA_COMB_MIXED) begin // RULE_10
			act_cur[0] = (SAMPLE_W+1)'(curr_a) - (SAMPLE_W+1)'(curr_b);
			rea_cur[0] = (SAMPLE_W+1)'(quad_a) - (SAMPLE_W+1)'(quad_b);
			act_cur[1] = '0;
			rea_cur[1] = '0;
		end
		if (comb_sel == LEA_COMB_DELTA) begin // RULE_10
			act_cur[2] = (SAMPLE_W+1)'(curr_c) - (SAMPLE_W+1)'(curr_b);
			rea_cur[2] = (SAMPLE_W+1)'(quad_c) - (SAMPLE_W+1)'(quad_b);
		end
		for (int k = 0; k < 3; k++) begin
			act_prod[k] = TW'(volt[k]) * TW'(act_cur[k]);
			rea_prod[k] = TW'(volt[k]) * TW'(rea_cur[k]); // RULE_18
		end
	end

	// First order low-pass per term to extract the dc power
	logic signed [TW-1:0] act_lpf_reg [3];
	logic signed [TW-1:0] rea_lpf_reg [3];

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 0; k < 3; k++) begin
				act_lpf_reg[k] <= '0;
				rea_lpf_reg[k] <= '0;
			end
		end else if (sample_en) begin
			for (int k = 0; k < 3; k++) begin
				act_lpf_reg[k] <= act_lpf_reg[k] + TW'(((TW+1)'(act_prod[k])
					- (TW+1)'(act_lpf_reg[k])) >>> LEA_LPF_SH);
				rea_lpf_reg[k] <= rea_lpf_reg[k] + TW'(((TW+1)'(rea_prod[k])
					- (TW+1)'(rea_lpf_reg[k])) >>> LEA_LPF_SH); // RULE_18
			end
		end
	end

	// Sum of enabled terms
	logic signed [SW-1:0] act_signed_sum;
	logic signed [SW-1:0] act_abs_sum;
	logic signed [SW-1:0] rea_sum;
	logic signed [SW-1:0] la_inc;
	logic signed [SW-1:0] lva_inc;

	always_comb begin
		act_signed_sum = '0;
		act_abs_sum    = '0;
		rea_sum        = '0;
		for (int k = 0; k < 3; k++) begin
			if (line_term_select[k]) begin // RULE_09 RULE_15
				act_signed_sum = act_signed_sum + SW'(act_lpf_reg[k]);
				act_abs_sum = act_abs_sum + (act_lpf_reg[k] < 0 ? -SW'(act_lpf_reg[k])
					: SW'(act_lpf_reg[k])); // RULE_14 RULE_17
				rea_sum = rea_sum + SW'(rea_lpf_reg[k]); // RULE_19
			end
		end
		if (reactive_mode) begin // RULE_13
			la_inc  = rea_sum;
			lva_inc = act_abs_sum; // RULE_14
		end else begin
			la_inc  = abs_mode ? act_abs_sum : act_signed_sum; // RULE_16 RULE_17
			lva_inc = SW'(apparent_power);
		end
	end

	// Half-cycle counting
	lea_state_t  state_reg;
	lea_state_t  state_next;
	logic [15:0] cycles_left_reg;
	logic [1:0]  hits;
	logic        period_end;

	always_comb begin
		hits = 2'(zero_cross[0] & phase_sel[0]) + 2'(zero_cross[1] & phase_sel[1])
			+ 2'(zero_cross[2] & phase_sel[2]); // RULE_04
		period_end = state_reg == LEA_ST_RUN && !wr_half && hits != 2'h0
			&& half_cycle_count_reg != 16'h0000 && cycles_left_reg <= 16'(hits);
		state_next = half_cycle_count_reg == 16'h0000 ? LEA_ST_HOLD : LEA_ST_RUN;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg       <= LEA_ST_HOLD;
			cycles_left_reg <= LEA_HALF_CYCLE_RST;
		end else begin
			state_reg <= state_next;
			case (state_reg)
				LEA_ST_HOLD: cycles_left_reg <= half_cycle_count_reg;
				LEA_ST_RUN: begin
					if (wr_half)
						cycles_left_reg <= reg_wdata;
					else if (period_end)
						cycles_left_reg <= half_cycle_count_reg; // RULE_21
					else
						cycles_left_reg <= cycles_left_reg - 16'(hits); // RULE_01
				end
				default: cycles_left_reg <= half_cycle_count_reg;
			endcase
		end
	end

	// Line accumulators, running with no enable
	logic signed [ACC_W-1:0]       la_acc_reg;
	logic        [ACC_W-1:0]       lva_acc_reg;
	logic signed [LEA_RDATA_W-1:0] line_active_energy;
	logic        [LEA_RDATA_W-1:0] line_apparent_energy;
	logic signed [ACC_W-1:0]       la_step;
	logic        [ACC_W-1:0]       lva_step;

	assign la_step  = ACC_W'(la_inc) <<< LEA_LINE_SCALE_SH; // RULE_12
	assign lva_step = ACC_W'(lva_inc) << LEA_LINE_SCALE_SH; // RULE_12

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			la_acc_reg  <= '0;
			lva_acc_reg <= '0;
		end else if (wr_half || period_end) begin
			la_acc_reg  <= sample_en ? la_step : '0; // RULE_21
			lva_acc_reg <= sample_en ? lva_step : '0;
		end else if (sample_en) begin
			la_acc_reg  <= la_acc_reg + la_step; // RULE_01 RULE_02
			lva_acc_reg <= lva_acc_reg + lva_step;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			line_active_energy   <= '0;
			line_apparent_energy <= '0;
			period_done          <= 1'b0;
		end else begin
			period_done <= period_end;
			if (period_end) begin
				line_active_energy   <= la_acc_reg[OUT_LSB +: LEA_RDATA_W]; // RULE_21
				line_apparent_energy <= lva_acc_reg[OUT_LSB +: LEA_RDATA_W];
			end
		end
	end

	// End-of-period flag; a completion beats a clearing read
	logic line_flag_reg;
	logic status_read;

	assign status_read = reg_re && reg_addr == LEA_ADDR_IRQ_STATUS;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			line_flag_reg <= 1'b0;
		else if (period_end)
			line_flag_reg <= 1'b1; // RULE_07
		else if (status_read)
			line_flag_reg <= 1'b0;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_n_o  <= 1'b0;
			irq_n_oe <= 1'b0;
		end else begin
			irq_n_o  <= 1'b0;
			irq_n_oe <= line_flag_reg && irq_enable_reg[LEA_IRQ_LINE_BIT]; // RULE_08
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			zx_enable <= 3'h0;
		else
			zx_enable <= phase_sel; // RULE_05
	end

	// Register reads
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_re) begin
			case (reg_addr)
				LEA_ADDR_LINE_ACTIVE:   reg_rdata <= line_active_energy;
				LEA_ADDR_LINE_APPARENT: reg_rdata <= line_apparent_energy;
				LEA_ADDR_MEASUREMENT_MODE_REG:         reg_rdata <= {16'h0000, measurement_mode_reg_reg};
				LEA_ADDR_WAVEFORM:      reg_rdata <= {16'h0000, waveform_reg};
				LEA_ADDR_POWER_MODE:    reg_rdata <= {16'h0000, power_mode_reg};
				LEA_ADDR_GAIN:          reg_rdata <= {16'h0000, gain_reg};
				LEA_ADDR_IRQ_ENABLE:    reg_rdata <= {16'h0000, irq_enable_reg};
				LEA_ADDR_IRQ_STATUS:    reg_rdata <= {23'h0, line_flag_reg};
				LEA_ADDR_HALF_CYCLE:    reg_rdata <= {8'h00, half_cycle_count_reg};
				default:                reg_rdata <= '0;
			endcase
		end
	end
endmodule

// [sim/lea_line_energy_checker.sv]
// Port checker for the line energy accumulator
`timescale 1ns/10ps
module lea_line_energy_checker (
	// Clock and reset
	input wire logic                            mclk,
	input wire logic                            resetn,
	// Register port
	input wire logic [lea_pkg::LEA_ADDR_W-1:0]  reg_addr,
	input wire logic                            reg_we,
	input wire logic [lea_pkg::LEA_WDATA_W-1:0] reg_wdata,
	input wire logic                            reg_re,
	input wire logic [lea_pkg::LEA_RDATA_W-1:0] reg_rdata,
	// Phase and event signals
	input wire logic [2:0]                      zero_cross,
	input wire logic [2:0]                      zx_enable,
	input wire logic                            period_done,
	input wire logic                            irq_n_o,
	input wire logic                            irq_n_oe
);
	import lea_pkg::*;
	logic mm_wr;
	logic en_wr;
	logic st_rd;
	assign mm_wr = reg_we && reg_addr == LEA_ADDR_MEASUREMENT_MODE_REG;
	assign en_wr = reg_we && reg_addr == LEA_ADDR_IRQ_ENABLE;
	assign st_rd = reg_re && reg_addr == LEA_ADDR_IRQ_STATUS;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	zx_follow_a: assert property (
		mm_wr |-> ##2 zx_enable == $past(reg_wdata[6:4], 2)) else $error("zx enable not loaded");
	zx_hold_a: assert property (
		!$past(mm_wr) && !$past(mm_wr, 2) |-> $stable(zx_enable)) else $error("zx enable moved");
	done_cause_a: assert property (
		period_done |-> |(zx_enable & $past(zero_cross))) else $error("period end without crossing");
	done_restart_a: assert property (
		reg_we && reg_addr == LEA_ADDR_HALF_CYCLE |=> !period_done) else $error("end on restart");
	irq_rise_a: assert property (
		$rose(irq_n_oe) |-> $past(period_done) || $past(en_wr, 2)) else $error("irq without cause");
	irq_fall_a: assert property (
		$fell(irq_n_oe) |-> $past(st_rd, 2) || $past(en_wr, 2)) else $error("irq dropped early");
	irq_drive_a: assert property (
		irq_n_oe |-> !irq_n_o) else $error("irq line driven high");
	rdata_hold_a: assert property (
		!$past(reg_re) |-> $stable(reg_rdata)) else $error("read data moved");
endmodule
bind lea_line_energy lea_line_energy_checker u_lea_line_energy_checker (.mclk(mclk),
	.resetn(resetn), .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata),
	.reg_re(reg_re), .reg_rdata(reg_rdata), .zero_cross(zero_cross), .zx_enable(zx_enable),
	.period_done(period_done), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));

// [sim/lea_host.sv]
// Host model that reaches the registers
`timescale 1ns/10ps
module lea_host (
	// Clock
	input  wire logic                            mclk,
	// Register port
	output logic      [lea_pkg::LEA_ADDR_W-1:0]  reg_addr,
	output logic                                 reg_we,
	output logic      [lea_pkg::LEA_WDATA_W-1:0] reg_wdata,
	output logic                                 reg_re,
	input  wire logic [lea_pkg::LEA_RDATA_W-1:0] reg_rdata
);
	import lea_pkg::*;
	initial begin
		reg_addr = 6'h00;
		reg_we = 1'b0;
		reg_wdata = 16'h0000;
		reg_re = 1'b0;
	end
	// Idle address and data show the inverse of the last value
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge mclk);
		reg_we <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task rd(input logic [5:0] a, output logic [23:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge mclk);
		reg_re <= 1'b0;
		reg_addr <= ~a;
		@(posedge mclk);
		d = reg_rdata;
	endtask
endmodule

// [sim/tb_line_energy_accumulator.sv]
// Self-checking bench for the line energy accumulator
`timescale 1ns/10ps
module tb_line_energy_accumulator;
	import lea_pkg::*;
	logic               mclk;
	logic               resetn;
	logic [5:0]         reg_addr;
	logic               reg_we;
	logic [15:0]        reg_wdata;
	logic               reg_re;
	logic [23:0]        reg_rdata;
	logic signed [15:0] volt;
	logic signed [15:0] curr;
	logic signed [15:0] quad;
	logic [2:0]         zero_cross;
	logic [2:0]         zx_enable;
	logic               period_done;
	logic               irq_n_o;
	logic               irq_n_oe;
	logic [23:0]        la;
	logic [23:0]        lv;
	logic [23:0]        r;
	logic [31:0]        apparent;
	int                 error_cnt;
	int                 check_count;
	int                 done_cnt;
	lea_line_energy u_lea_line_energy (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_we(reg_we), .reg_wdata(reg_wdata), .reg_re(reg_re), .reg_rdata(reg_rdata),
		.volt_a(volt), .volt_b(volt), .volt_c(volt), .curr_a(curr), .curr_b(curr),
		.curr_c(curr), .quad_a(quad), .quad_b(quad), .quad_c(quad),
		.apparent_power(apparent), .zero_cross(zero_cross), .zx_enable(zx_enable),
		.period_done(period_done), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
	lea_host u_lea_host (.mclk(mclk), .reg_addr(reg_addr), .reg_we(reg_we),
		.reg_wdata(reg_wdata), .reg_re(reg_re), .reg_rdata(reg_rdata));
	initial mclk = 1'b0;
	always #2 mclk = ~mclk;
	always @(negedge mclk) if (period_done === 1'b1) done_cnt++;
	task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One period of n selected crossings, each trailed by an unselected phase B pulse
	task run_period(input int n);
		u_lea_host.wr(LEA_ADDR_HALF_CYCLE, n[15:0]);
		done_cnt = 0;
		for (int i = 0; i < n; i++) begin
			repeat (100) @(posedge mclk);
			check("early end", done_cnt[23:0], 24'h0);
			zero_cross <= 3'h1;
			@(posedge mclk);
			zero_cross <= 3'h2;
			@(posedge mclk);
			zero_cross <= 3'h0;
		end
		repeat (4) @(posedge mclk);
		check("period end", done_cnt[23:0], 24'h1);
		u_lea_host.rd(LEA_ADDR_LINE_ACTIVE, la);
		u_lea_host.rd(LEA_ADDR_LINE_APPARENT, lv);
	endtask
	// Mid-run reset clears the filters; phase select must be written again
	task reset_dut;
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
	endtask
	task t_reset;
		u_lea_host.rd(LEA_ADDR_POWER_MODE, r);
		check("power mode", r, 24'h38);
		u_lea_host.rd(LEA_ADDR_HALF_CYCLE, r);
		check("half count", r, 24'hffff);
		u_lea_host.rd(6'h3f, r);
		check("unmapped", r, 24'h0);
		$display("t_reset done");
	endtask
	task t_count;
		u_lea_host.wr(LEA_ADDR_MEASUREMENT_MODE_REG, 16'h0010);
		repeat (3) @(posedge mclk);
		check("zx enable", {21'h0, zx_enable}, 24'h1);
		run_period(3);
		check("active nonzero", {23'h0, la != 0 && !la[23]}, 24'h1);
		check("apparent sum", {23'h0, lv != 0}, 24'h1);
		$display("t_count done");
	endtask
	task t_irq;
		u_lea_host.rd(LEA_ADDR_IRQ_STATUS, r);
		check("flag", r, 24'h1);
		check("irq off", {23'h0, irq_n_oe}, 24'h0);
		u_lea_host.wr(LEA_ADDR_IRQ_ENABLE, 16'h0001);
		run_period(1);
		check("irq on", {23'h0, irq_n_oe}, 24'h1);
		u_lea_host.rd(LEA_ADDR_IRQ_STATUS, r);
		check("flag set", r, 24'h1);
		repeat (3) @(posedge mclk);
		check("irq cleared", {23'h0, irq_n_oe}, 24'h0);
		$display("t_irq done");
	endtask
	task t_sign;
		curr <= 16'hc000;
		reset_dut;
		t_reset;
		u_lea_host.wr(LEA_ADDR_MEASUREMENT_MODE_REG, 16'h0010);
		run_period(1);
		check("signed sum", {23'h0, la[23]}, 24'h1);
		u_lea_host.wr(LEA_ADDR_GAIN, 16'h0004);
		run_period(1);
		check("abs sum", {23'h0, la != 0 && !la[23]}, 24'h1);
		u_lea_host.wr(LEA_ADDR_GAIN, 16'h0000);
		curr <= 16'h4000;
		$display("t_sign done");
	endtask
	task t_terms;
		reset_dut;
		u_lea_host.wr(LEA_ADDR_POWER_MODE, 16'h0078);
		u_lea_host.wr(LEA_ADDR_MEASUREMENT_MODE_REG, 16'h0010);
		run_period(1);
		check("delta", la, 24'h0);
		u_lea_host.wr(LEA_ADDR_POWER_MODE, 16'h00b8);
		run_period(1);
		check("mixed", {23'h0, la != 0 && !la[23]}, 24'h1);
		u_lea_host.wr(LEA_ADDR_POWER_MODE, 16'h0000);
		run_period(1);
		check("no terms", la, 24'h0);
		$display("t_terms done");
	endtask
	task t_reactive;
		u_lea_host.wr(LEA_ADDR_POWER_MODE, 16'h0038);
		u_lea_host.wr(LEA_ADDR_WAVEFORM, 16'h0020);
		curr <= 16'hc000;
		run_period(1);
		check("var sign", {23'h0, la != 0 && !la[23]}, 24'h1);
		check("active unsigned", {23'h0, lv != 0}, 24'h1);
		u_lea_host.wr(LEA_ADDR_POWER_MODE, 16'h0000);
		run_period(1);
		check("var no terms", la, 24'h0);
		check("lv no terms", lv, 24'h0);
		$display("t_reactive done");
	endtask
	initial begin
		#400000;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		resetn = 1'b0;
		zero_cross = 3'h0;
		volt = 16'h4000;
		curr = 16'h4000;
		quad = 16'h4000;
		apparent = 32'h01000000;
		error_cnt = 0;
		check_count = 0;
		done_cnt = 0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_reset;
		t_count;
		t_irq;
		t_sign;
		t_terms;
		t_reactive;
		tally_and_finish;
	end
endmodule
